// *** common/sras_pkg.sv ***
package sras_pkg;

  // ************************************************************
  // link format
  // ************************************************************
  localparam int ADDR_W = 14;
  localparam logic [7:0] INSTR_READ = 8'h0B;
  localparam logic [7:0] INSTR_WRITE = 8'h02;
  localparam logic [1:0] DIR_INC = 2'h0;
  localparam logic [1:0] DIR_INC_ALT = 2'h1;
  localparam logic [1:0] DIR_DEC = 2'h2;
  localparam logic [1:0] DIR_FIXED = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] READ_AHEAD_BIT = 3'h2;
  localparam logic [2:0] HDR_DATA_IDX = 3'h4;

  // ************************************************************
  // reset values and fixed addresses
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 14'h0010;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SYS_CLK_MHZ = 40;
  localparam int SYS_PERIOD_NS = 1000 / SYS_CLK_MHZ;
  localparam int CS_GAP_NS = 50;
  localparam int CS_GAP_CYC = (CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 4;
  localparam logic [3:0] GAP_LAST = 4'(CS_GAP_CYC - 1);
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);

  // ************************************************************
  // state types
  // ************************************************************
  typedef enum logic [2:0] {
    PH_INSTR, PH_ADDRH, PH_ADDRL, PH_DUMMY, PH_DATA, PH_IGNORE
  } sras_phase_e;

  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_GAP} sras_hstate_e;

endpackage

// *** common/sras_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface sras_if;
  logic sclk;
  logic csN;
  logic serial_in_line;
  logic sdo;
  logic sdoEn;
  logic sdoLine;

  // undriven data line is pulled high
  assign sdoLine = sdoEn ? sdo : 1'b1;

  modport dev (
    input sclk,
    input csN,
    input serial_in_line,
    output sdo,
    output sdoEn
  );

  modport host (
    output sclk,
    output csN,
    output serial_in_line,
    input sdoLine
  );
endinterface

`default_nettype wire

// *** logic/sras_cor_status.sv ***
`timescale 1ns/10ps
`default_nettype none

module sras_cor_status (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] hwEvent,
  input wire logic capture,
  output logic [7:0] statusVal
);
  import sras_pkg::*;

  logic clrDue;
  logic [7:0] pend;

  // ************************************************************
  // clear-on-read status with pending events
  // ************************************************************
  // clear lands one edge after the capture
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clrDue <= 1'b0;
    end else begin
      clrDue <= capture;
    end
  end

  // events inside the capture..clear window wait, then set afresh
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      statusVal <= BYTE_RESET;
      pend <= BYTE_RESET;
    end else if (capture || clrDue) begin
      pend <= pend | hwEvent;
      if (clrDue) begin
        statusVal <= BYTE_RESET;
      end else begin
        statusVal <= statusVal;
      end
    end else begin
      statusVal <= statusVal | hwEvent | pend;
      pend <= BYTE_RESET;
    end
  end
endmodule

`default_nettype wire

// *** logic/sras_device.sv ***
`timescale 1ns/10ps
`default_nettype none

module sras_device (
  input wire logic sys_clk,
  input wire logic reset,
  sras_if.dev link,
  input wire logic [7:0] hwEvent,
  input wire logic [7:0] regRdData,
  output logic [sras_pkg::ADDR_W-1:0] regAddr,
  output logic regRdStb,
  output logic regWrStb,
  output logic [7:0] regWrData,
  output logic [7:0] statusVal
);
  import sras_pkg::*;

  // ************************************************************
  // decoding helpers
  // ************************************************************
  // next byte address for the held stepping code
  function automatic logic [ADDR_W-1:0] stepAddr(
    input logic [ADDR_W-1:0] a,
    input logic [1:0] d
  );
    logic [ADDR_W-1:0] r;
    r = a;
    unique case (d)
      DIR_INC, DIR_INC_ALT: r = a + 14'h0001;
      DIR_DEC: r = a - 14'h0001;
      DIR_FIXED: r = a;
    endcase
    return r;
  endfunction

  function automatic logic isStatus(input logic [ADDR_W-1:0] a);
    return a == STATUS_ADDR;
  endfunction

  // ************************************************************
  // link domain, serial clock
  // ************************************************************
  sras_phase_e phase;
  logic [2:0] bitCnt;
  logic [6:0] shIn;
  logic [7:0] byteVal;
  logic isRead;
  logic [1:0] dir;
  logic [5:0] addrHi;
  logic [ADDR_W-1:0] curAddr;
  logic reqTog;
  logic reqWr;
  logic [ADDR_W-1:0] reqAddr;
  logic [7:0] reqData;
  logic [7:0] shOut;
  logic outEn;
  logic [7:0] rdHold;

  assign byteVal = {shIn, link.serial_in_line};

  // bit counter and input shifter, cleared while deselected
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      bitCnt <= 3'h0;
      shIn <= 7'h00;
    end else begin
      bitCnt <= bitCnt + 3'h1;
      shIn <= {shIn[5:0], link.serial_in_line};
    end
  end

  // frame field sequencing
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      phase <= PH_INSTR;
      isRead <= 1'b0;
      dir <= DIR_INC;
      addrHi <= 6'h00;
      curAddr <= ADDR_RESET;
    end else if (bitCnt == BIT_LAST) begin
      unique case (phase)
        PH_INSTR: begin
          if (byteVal == INSTR_READ) begin
            isRead <= 1'b1;
            phase <= PH_ADDRH;
          end else if (byteVal == INSTR_WRITE) begin
            phase <= PH_ADDRH;
          end else begin
            phase <= PH_IGNORE;
          end
        end
        PH_ADDRH: begin
          dir <= byteVal[7:6];
          addrHi <= byteVal[5:0];
          phase <= PH_ADDRL;
        end
        PH_ADDRL: begin
          curAddr <= {addrHi, byteVal};
          phase <= isRead ? PH_DUMMY : PH_DATA;
        end
        PH_DUMMY: phase <= PH_DATA;
        PH_DATA: begin
          if (!isRead) begin
            curAddr <= stepAddr(curAddr, dir);
          end
        end
        PH_IGNORE: phase <= PH_IGNORE;
      endcase
    end else if (phase == PH_DATA && isRead && bitCnt == READ_AHEAD_BIT) begin
      curAddr <= stepAddr(curAddr, dir);
    end
  end

  // requests toward the system side; word held until next toggle
  always_ff @(posedge link.sclk or posedge reset) begin
    if (reset) begin
      reqTog <= 1'b0;
      reqWr <= 1'b0;
      reqAddr <= ADDR_RESET;
      reqData <= BYTE_RESET;
    end else if (!link.csN && bitCnt == BIT_LAST &&
                 phase == PH_ADDRL && isRead) begin
      reqTog <= ~reqTog;
      reqWr <= 1'b0;
      reqAddr <= {addrHi, byteVal};
    end else if (!link.csN && bitCnt == BIT_LAST &&
                 phase == PH_DATA && !isRead) begin
      reqTog <= ~reqTog;
      reqWr <= 1'b1;
      reqAddr <= curAddr;
      reqData <= byteVal;
    end else if (!link.csN && phase == PH_DATA && isRead &&
                 bitCnt == READ_AHEAD_BIT) begin
      reqTog <= ~reqTog;
      reqWr <= 1'b0;
      reqAddr <= stepAddr(curAddr, dir);
    end
  end

  // output shifter launched on the falling edge
  always_ff @(negedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      shOut <= BYTE_RESET;
      outEn <= 1'b0;
    end else if (phase == PH_DATA && isRead && bitCnt == 3'h0) begin
      shOut <= rdHold;
      outEn <= 1'b1;
    end else begin
      shOut <= {shOut[6:0], 1'b0};
    end
  end

  assign link.sdo = shOut[7];
  assign link.sdoEn = outEn;

  // ************************************************************
  // system domain
  // ************************************************************
  logic reqS1;
  logic reqS2;
  logic reqS3;
  logic reqSeen;
  logic rdPend;
  logic [7:0] readMux;

  assign reqSeen = reqS2 ^ reqS3;
  assign readMux = isStatus(regAddr) ? statusVal : regRdData;

  // request toggle synchroniser and edge detect
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
    end else begin
      reqS1 <= reqTog;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
    end
  end

  // register access strobes toward the user side
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regAddr <= ADDR_RESET;
      regWrData <= BYTE_RESET;
      regWrStb <= 1'b0;
      rdPend <= 1'b0;
    end else begin
      regWrStb <= reqSeen && reqWr;
      rdPend <= reqSeen && !reqWr;
      if (reqSeen) begin
        regAddr <= reqAddr;
        regWrData <= reqData;
      end
    end
  end

  // holding latch, side effect strobe one edge later
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdHold <= BYTE_RESET;
      regRdStb <= 1'b0;
    end else begin
      regRdStb <= rdPend;
      if (rdPend) begin
        rdHold <= readMux;
      end
    end
  end

  sras_cor_status u_status (
    .sys_clk(sys_clk),
    .reset(reset),
    .hwEvent(hwEvent),
    .capture(rdPend && isStatus(regAddr)),
    .statusVal(statusVal)
  );
endmodule

`default_nettype wire

// *** logic/sras_host.sv ***
`timescale 1ns/10ps
`default_nettype none

module sras_host #(
  parameter int LEN_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  sras_if.host link,
  input wire logic cmdValid,
  input wire logic cmdRead,
  input wire logic [sras_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic [1:0] cmdDir,
  input wire logic [LEN_W-1:0] cmdLen,
  input wire logic [7:0] wrData,
  output logic cmdReady,
  output logic dataStb,
  output logic [7:0] rdData
);
  import sras_pkg::*;

  // ************************************************************
  // frame byte generator
  // ************************************************************
  // header bytes, then dummy or write data
  function automatic logic [7:0] hdrByte(
    input logic [2:0] idx,
    input logic rd,
    input logic [1:0] d,
    input logic [ADDR_W-1:0] a,
    input logic [7:0] wd
  );
    logic [7:0] r;
    r = rd ? BYTE_RESET : wd;
    if (idx == 3'h0) begin
      r = rd ? INSTR_READ : INSTR_WRITE;
    end else if (idx == 3'h1) begin
      r = {d, a[13:8]};
    end else if (idx == 3'h2) begin
      r = a[7:0];
    end
    return r;
  endfunction

  sras_hstate_e state;
  logic sclkR;
  logic csNR;
  logic mosiR;
  logic misoS1;
  logic misoS2;
  logic [3:0] halfCnt;
  logic [2:0] bitCnt;
  logic [2:0] byteIdx;
  logic [LEN_W:0] bytesLeft;
  logic [7:0] txByte;
  logic [7:0] rxByte;
  logic opRead;
  logic [1:0] opDir;
  logic [ADDR_W-1:0] opAddr;
  logic [2:0] nextIdx;
  logic [7:0] nextByte;
  logic curIsData;
  logic nextIsData;

  assign link.sclk = sclkR;
  assign link.csN = csNR;
  assign link.serial_in_line = mosiR;
  assign nextIdx = (byteIdx == HDR_DATA_IDX) ? byteIdx : byteIdx + 3'h1;
  assign nextByte = hdrByte(nextIdx, opRead, opDir, opAddr, wrData);
  assign curIsData = byteIdx >= (opRead ? 3'h4 : 3'h3);
  assign nextIsData = nextIdx >= (opRead ? 3'h4 : 3'h3);

  // returned data line synchroniser
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      misoS1 <= 1'b1;
      misoS2 <= 1'b1;
    end else begin
      misoS1 <= link.sdoLine;
      misoS2 <= misoS1;
    end
  end

  // ************************************************************
  // frame sequencer, clock idles low
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= HS_IDLE;
      cmdReady <= 1'b0;
      sclkR <= 1'b0;
      csNR <= 1'b1;
      mosiR <= 1'b0;
      halfCnt <= 4'h0;
      bitCnt <= 3'h0;
      byteIdx <= 3'h0;
      bytesLeft <= '0;
      txByte <= BYTE_RESET;
      rxByte <= BYTE_RESET;
      opRead <= 1'b0;
      opDir <= DIR_INC;
      opAddr <= ADDR_RESET;
      dataStb <= 1'b0;
      rdData <= BYTE_RESET;
    end else begin
      dataStb <= 1'b0;
      unique case (state)
        HS_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            opRead <= cmdRead;
            opDir <= cmdDir;
            opAddr <= cmdAddr;
            csNR <= 1'b0;
            txByte <= hdrByte(3'h0, cmdRead, cmdDir, cmdAddr, wrData);
            mosiR <= cmdRead ? INSTR_READ[7] : INSTR_WRITE[7];
            byteIdx <= 3'h0;
            bitCnt <= 3'h0;
            halfCnt <= 4'h0;
            bytesLeft <= (cmdRead ? (LEN_W+1)'(4) : (LEN_W+1)'(3)) +
                         {1'b0, cmdLen} - (LEN_W+1)'(1);
            state <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          halfCnt <= halfCnt + 4'h1;
          if (halfCnt == HALF_LAST) begin
            halfCnt <= 4'h0;
            if (!sclkR) begin
              sclkR <= 1'b1;
              rxByte <= {rxByte[6:0], misoS2};
            end else begin
              sclkR <= 1'b0;
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == BIT_LAST) begin
                if (curIsData && opRead) begin
                  dataStb <= 1'b1;
                  rdData <= rxByte;
                end
                if (bytesLeft == '0) begin
                  csNR <= 1'b1;
                  state <= HS_GAP;
                end else begin
                  bytesLeft <= bytesLeft - (LEN_W+1)'(1);
                  byteIdx <= nextIdx;
                  txByte <= nextByte;
                  mosiR <= nextByte[7];
                  if (nextIsData && !opRead) begin
                    dataStb <= 1'b1;
                  end
                end
              end else begin
                mosiR <= txByte[6];
                txByte <= {txByte[6:0], 1'b0};
              end
            end
          end
        end
        HS_GAP: begin
          halfCnt <= halfCnt + 4'h1;
          if (halfCnt == GAP_LAST) begin
            halfCnt <= 4'h0;
            state <= HS_IDLE;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// *** tb/sras_link_sva.sv ***
`timescale 1ns/10ps
`default_nettype none

module sras_link_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic csN,
  input wire logic serial_in_line,
  input wire logic sdo,
  input wire logic sdoEn,
  input wire logic sdoLine
);
  import sras_pkg::*;
  logic sclkQ;
  logic [7:0] bitCnt;
  logic [7:0] instr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ************************************************************
  // frame tracking
  // ************************************************************
  // delayed serial clock for edge detection
  always_ff @(posedge sys_clk) begin
    sclkQ <= sclk;
  end
  // rising serial clock edges counted within a frame
  always_ff @(posedge sys_clk) begin
    if (reset || csN) begin
      bitCnt <= 8'h00;
    end else if (sclk && !sclkQ && bitCnt != 8'hFF) begin
      bitCnt <= bitCnt + 8'h01;
    end
  end
  // first byte of the frame
  always_ff @(posedge sys_clk) begin
    if (!csN && sclk && !sclkQ && bitCnt < 8'h08) begin
      instr <= {instr[6:0], serial_in_line};
    end
  end

  property p_idleOff;
    csN && $past(csN) |-> !sdoEn;
  endproperty
  a_idleOff: assert property (p_idleOff)
    else $error("data out driven while deselected");
  property p_sclkIdle;
    csN |-> !sclk;
  endproperty
  a_sclkIdle: assert property (p_sclkIdle)
    else $error("serial clock not idle between frames");
  property p_firstRise;
    $fell(csN) |-> !sclk ##[1:8] $rose(sclk);
  endproperty
  a_firstRise: assert property (p_firstRise)
    else $error("no clock rise after select fell");
  property p_mosiOnFall;
    !csN && !$past(csN) && $changed(serial_in_line) |-> $fell(sclk);
  endproperty
  a_mosiOnFall: assert property (p_mosiOnFall)
    else $error("data in changed off the falling clock");
  property p_sdoOnFall;
    !csN && sdoEn && $past(sdoEn) && $changed(sdo) |-> $fell(sclk);
  endproperty
  a_sdoOnFall: assert property (p_sdoOnFall)
    else $error("data out changed off the falling clock");
  property p_enStart;
    $rose(sdoEn) |-> $fell(sclk) && bitCnt == 8'h20;
  endproperty
  a_enStart: assert property (p_enStart)
    else $error("data out began at the wrong bit");
  property p_readOnly;
    !csN && sdoEn |-> instr == INSTR_READ && bitCnt >= 8'h20;
  endproperty
  a_readOnly: assert property (p_readOnly)
    else $error("data out driven outside read data");
  property p_wholeBytes;
    $rose(csN) |-> bitCnt[2:0] == 3'h0 && bitCnt >= 8'h20;
  endproperty
  a_wholeBytes: assert property (p_wholeBytes)
    else $error("frame not whole bytes");
  property p_gap;
    $rose(csN) |-> csN [*2];
  endproperty
  a_gap: assert property (p_gap)
    else $error("select gap too short");
  property p_halfPeriod;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_halfPeriod: assert property (p_halfPeriod)
    else $error("serial clock high time wrong");

  c_readOut: cover property ($rose(sdoEn));
  c_lowBit: cover property (sdoEn && !sdoLine);
  c_writeDone: cover property ($rose(csN) && instr == INSTR_WRITE);
  c_burst: cover property ($rose(csN) && bitCnt >= 8'h30);
endmodule

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module tb;
  import sras_pkg::*;
  typedef struct {logic rd; logic [13:0] a; logic [1:0] d; logic [7:0] n;
    logic [7:0] v;} sras_row_s;
  logic sys_clk = 1'b0;
  logic reset = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  logic cmdValid = 1'b0, cmdRead = 1'b0, cmdReady, dataStb;
  logic [13:0] cmdAddr = 14'h0000, regAddr, addrB, lastAddrB;
  logic [1:0] cmdDir = 2'h0;
  logic [7:0] cmdLen = 8'h01, wrData = 8'h00, rdData, regRdData, regWrData;
  logic [7:0] hwEvent, evNow = 8'h00, evPulse = 8'h00, statusVal, dataB;
  logic [7:0] lastDataB;
  logic regRdStb, regWrStb, wrStbB, armEv = 1'b0, enSeenB = 1'b0;
  logic [7:0] mem [0:16383];
  logic [7:0] expMem [0:16383];
  sras_row_s rows [9];
  int wrCntB = 0;
  sras_if lnk();
  sras_if lnkB();

  sras_host i_sras_host (.sys_clk(sys_clk), .reset(reset), .link(lnk),
    .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdAddr(cmdAddr),
    .cmdDir(cmdDir), .cmdLen(cmdLen), .wrData(wrData),
    .cmdReady(cmdReady), .dataStb(dataStb), .rdData(rdData));
  sras_device i_sras_device (.sys_clk(sys_clk), .reset(reset), .link(lnk),
    .hwEvent(hwEvent), .regRdData(regRdData), .regAddr(regAddr),
    .regRdStb(regRdStb), .regWrStb(regWrStb), .regWrData(regWrData),
    .statusVal(statusVal));
  sras_device i_sras_device_b (.sys_clk(sys_clk), .reset(reset),
    .link(lnkB), .hwEvent(8'h00), .regRdData(8'h00), .regAddr(addrB),
    .regRdStb(), .regWrStb(wrStbB), .regWrData(dataB), .statusVal());
  sras_link_sva i_sras_link_sva (.sys_clk(sys_clk), .reset(reset),
    .sclk(lnk.sclk), .csN(lnk.csN), .serial_in_line(lnk.serial_in_line),
    .sdo(lnk.sdo), .sdoEn(lnk.sdoEn), .sdoLine(lnk.sdoLine));

  // ************************************************************
  // user side models
  // ************************************************************
  // register file behind the first device
  assign regRdData = mem[regAddr];
  always @(posedge sys_clk) begin
    if (regWrStb === 1'b1) mem[regAddr] <= regWrData;
  end
  // one event pulse on the first clear cycle while armed
  assign hwEvent = evNow | evPulse;
  always @(negedge sys_clk) begin
    if (armEv && regRdStb === 1'b1) begin
      evPulse = 8'h40;
      armEv = 1'b0;
    end else begin
      evPulse = 8'h00;
    end
  end
  // writes and drive seen on the second device
  always @(posedge sys_clk) begin
    if (wrStbB === 1'b1) begin
      wrCntB++;
      lastAddrB = addrB;
      lastDataB = dataB;
    end
    if (lnkB.sdoEn !== 1'b0) enSeenB = 1'b1;
  end

  initial forever #12.5 sys_clk = ~sys_clk;
  initial begin
    #500000;
    err_count++;
    wrap_up();
  end

  // next byte address for a step code
  function automatic logic [13:0] stepA(input logic [13:0] a,
      input logic [1:0] d);
    return d == DIR_DEC ? a - 14'h0001 : d == DIR_FIXED ? a : a + 14'h0001;
  endfunction

  // one host command, checking read bytes against the expected map
  task automatic run_op(input sras_row_s r);
    logic [13:0] a;
    int w;
    a = r.a;
    w = 0;
    while (cmdReady !== 1'b1 && w < 900) begin
      @(negedge sys_clk);
      w++;
    end
    {cmdRead, cmdAddr, cmdDir, cmdLen, wrData} = {r.rd, r.a, r.d, r.n, r.v};
    cmdValid = 1'b1;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    for (int k = 0; k < r.n; k++) begin
      w = 0;
      while (dataStb !== 1'b1 && w < 900) begin
        @(negedge sys_clk);
        w++;
      end
      `CHK(dataStb, 1'b1)
      if (r.rd) `CHK(rdData, expMem[a])
      else begin
        expMem[a] = r.v + 8'(k);
        wrData = r.v + 8'(k + 1);
      end
      a = stepA(a, r.d);
      @(negedge sys_clk);
    end
  endtask

  // ************************************************************
  // hand-driven frames on the second link, 12 ns serial clock
  // ************************************************************
  task automatic bang(input logic [31:0] bits, input int nb, input logic m3);
    lnkB.sclk = m3;
    #3 lnkB.csN = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      #6 lnkB.sclk = 1'b0;
      lnkB.serial_in_line = bits[i];
      #6 lnkB.sclk = 1'b1;
    end
    #6 lnkB.sclk = m3;
    #200 lnkB.csN = 1'b1;
    lnkB.serial_in_line = ~lnkB.serial_in_line;
    #300;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    // raise reset and deselect after time zero so async clears see an edge
    #1;
    reset = 1'b1;
    {lnkB.sclk, lnkB.csN, lnkB.serial_in_line} = 3'b010;
    for (int i = 0; i < 16384; i++) begin
      mem[i] = 8'h00;
      expMem[i] = 8'h00;
    end
    // first read throwaway steps incl. 01 and 14-bit wrap
    rows = '{'{1, 14'h0000, DIR_INC, 1, 0}, '{0, 14'h0100, DIR_INC, 3, 8'hA0},
      '{1, 14'h0100, DIR_INC_ALT, 3, 0}, '{0, 14'h0205, DIR_DEC, 3, 8'h50},
      '{1, 14'h0205, DIR_DEC, 3, 0}, '{0, 14'h0300, DIR_FIXED, 3, 8'h70},
      '{1, 14'h0300, DIR_FIXED, 2, 0}, '{0, 14'h3FFF, DIR_INC, 2, 8'hC0},
      '{1, 14'h0000, DIR_DEC, 2, 0}};
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    `CHK(lnk.sdoEn, 1'b0)
    `CHK(lnk.csN, 1'b1)
    foreach (rows[i]) run_op(rows[i]);
    // clear-on-read returns the old value, then clears
    evNow = 8'h05;
    @(negedge sys_clk);
    evNow = 8'h00;
    @(negedge sys_clk);
    `CHK(statusVal, 8'h05)
    expMem[STATUS_ADDR] = 8'h05;
    run_op('{1, STATUS_ADDR, DIR_INC, 1, 0});
    `CHK(statusVal, 8'h00)
    // event landing on the clear cycle survives it
    armEv = 1'b1;
    expMem[STATUS_ADDR] = 8'h00;
    run_op('{1, STATUS_ADDR, DIR_INC, 1, 0});
    repeat (3) @(negedge sys_clk);
    `CHK(statusVal, 8'h40)
    bang({8'h02, 8'h11, 8'h22, 8'h3C}, 32, 1'b1);
    `CHK(wrCntB, 1)
    `CHK({lastAddrB, lastDataB}, {14'h1122, 8'h3C})
    bang({8'h9F, 8'h11, 8'h22, 8'h3C}, 32, 1'b0);
    `CHK(wrCntB, 1)
    bang({8'h02, 8'h11, 8'h22, 8'h3C} >> 4, 28, 1'b0);
    `CHK(wrCntB, 1)
    bang({8'h02, 8'h00, 8'h07, 8'hA5}, 32, 1'b0);
    `CHK({lastAddrB, lastDataB}, {14'h0007, 8'hA5})
    `CHK(enSeenB, 1'b0)
    wrap_up();
  end
endmodule

`default_nettype wire
